// file: ecio_pkg.sv
// constants shared by the external control port and its helper modules
// assumes a single clock domain (pclk) and an apb master on the register side
package ecio_pkg;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [11:0] ECIO_OFS_CTRL  = 12'h000;
    localparam logic [11:0] ECIO_OFS_LIMIT = 12'h004;
    localparam logic [11:0] ECIO_OFS_CMD   = 12'h008;
    localparam logic [11:0] ECIO_OFS_PINS  = 12'h00C;

    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int ECIO_CTRL_MAINS = 0;
    localparam int ECIO_CTRL_OUTP  = 1;
    localparam int ECIO_CTRL_BUSY  = 2;
    localparam int ECIO_CTRL_SYNC  = 3;
    localparam int ECIO_SYNC_W     = 2;

    // ****************************************************************
    // command inputs, index into the command vector
    // ****************************************************************
    localparam int ECIO_N_CMD       = 7;
    localparam int ECIO_CMD_OFF     = 0;
    localparam int ECIO_CMD_ON      = 1;
    localparam int ECIO_CMD_START   = 2;
    localparam int ECIO_CMD_STOP    = 3;
    localparam int ECIO_CMD_HOLD    = 4;
    localparam int ECIO_CMD_BRANCH1 = 5;
    localparam int ECIO_CMD_BRANCH2 = 6;

    // ****************************************************************
    // limiter sources and pin readback layout
    // ****************************************************************
    localparam int ECIO_N_LIM       = 4;
    localparam int ECIO_PINS_STAT   = 0;
    localparam int ECIO_PINS_CMDLVL = 8;
    localparam int ECIO_N_STAT      = 7;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [31:0] ECIO_RST_CTRL = 32'h0000_0000;
    localparam logic [6:0]  ECIO_RST_CMD  = 7'h00;
    localparam logic [6:0]  ECIO_IDLE_PIN = 7'h7F;

    typedef struct packed {
        logic                   mains_on;
        logic                   outp_en;
        logic                   sw_busy;
        logic [ECIO_SYNC_W-1:0] seq_sync;
        logic [ECIO_N_CMD-1:0]  cmd_flags;
        logic [ECIO_N_CMD-1:0]  cmd_pulse;
        logic [31:0]            prdata;
    } ecio_main_st_t;

endpackage

// file: ecio_fedge.sv
// two-flop synchroniser and falling edge detector for idle-high command pins
// assumes pins are asynchronous to pclk and rest high when nobody drives them
`timescale 1ns/10ps
module ecio_fedge #(
    parameter int N = 7
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [N-1:0] pin_n,
    output logic      [N-1:0] level,
    output logic      [N-1:0] fall
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] fall;
    } ecio_fe_st_t;

    ecio_fe_st_t st_ff;
    ecio_fe_st_t nxt_st;
    logic [N-1:0] edge_det;

    if (N < 1) begin : g_bad_n
        $error("ecio_fedge: N must be at least 1");
    end

    // ****************************************************************
    // per pin edge detection, only the second flop onward is looked at
    // ****************************************************************
    for (genvar i = 0; i < N; i++) begin : g_pin
        assign edge_det[i] = st_ff.s3[i] & ~st_ff.s2[i];
    end

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.s1   = pin_n;
        nxt_st.s2   = st_ff.s1;
        nxt_st.s3   = st_ff.s2;
        nxt_st.fall = edge_det;
    end

    // resets to idle high so the release of reset never looks like a command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{s1: '1, s2: '1, s3: '1, fall: '0};
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.s3;
    assign fall  = st_ff.fall;
endmodule

// file: ecio_status.sv
// registered status pin driver of the external control port
// assumes all sources come from logic on pclk
`timescale 1ns/10ps
module ecio_status
    import ecio_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    input  wire logic                   mains_on,
    input  wire logic                   outp_en,
    input  wire logic [ECIO_N_LIM-1:0]  lim_act,
    input  wire logic                   sw_busy,
    input  wire logic [ECIO_SYNC_W-1:0] seq_sync,
    output logic      [ECIO_N_STAT-1:0] stat
);
    typedef struct packed {
        logic [ECIO_N_STAT-1:0] stat;
    } ecio_st_st_t;

    ecio_st_st_t st_ff;
    ecio_st_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // any one limiter raises the shared flag
        nxt_st.stat = {1'b0, seq_sync, sw_busy, |lim_act, outp_en, mains_on};
    end

    // pins never float: a flop drives them from reset on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign stat = st_ff.stat;
endmodule

// file: ecio_port.sv
// external control port: status pins, edge commands and apb registers
// assumes an apb master on pclk and pins asynchronous to pclk
`timescale 1ns/10ps
module ecio_port
    import ecio_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [ADDR_W-1:0]      paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [ECIO_N_CMD-1:0]  cmd_pin_n,
    input  wire logic                   lim_pos_peak,
    input  wire logic                   lim_neg_peak,
    input  wire logic                   lim_avg,
    input  wire logic                   lim_power,
    output logic                        mains_on_o,
    output logic                        outp_en_o,
    output logic                        limiter_o,
    output logic                        sw_busy_o,
    output logic      [ECIO_SYNC_W-1:0] seq_sync_o,
    output logic      [ECIO_N_CMD-1:0]  cmd_pulse
);
    ecio_main_st_t           st_ff;
    ecio_main_st_t           nxt_st;
    logic [ECIO_N_CMD-1:0]   cmd_level;
    logic [ECIO_N_CMD-1:0]   cmd_fall;
    logic [ECIO_N_CMD-1:0]   cmd_evt;
    logic [ECIO_N_LIM-1:0]   lim_act;
    logic [ECIO_N_STAT-1:0]  stat;
    logic [11:0]             addr;
    logic                    setup;
    logic                    wr_acc;
    logic                    mapped;
    logic [31:0]             rd_val;

    // the decoder compares twelve address bits, so wider buses are refused
    if (ADDR_W < 4 || ADDR_W > 12) begin : g_bad_addr_w
        $error("ecio_port: ADDR_W must be 4..12");
    end

    // ****************************************************************
    // command pins
    // ****************************************************************
    ecio_fedge #(
        .N       (ECIO_N_CMD)
    ) ecio_fedge_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .pin_n   (cmd_pin_n),
        .level   (cmd_level),
        .fall    (cmd_fall)
    );

    // a held-low pin gives one event only; the detector flop is frozen with ce
    assign cmd_evt = cmd_fall & {ECIO_N_CMD{ce}};

    // ****************************************************************
    // status pins
    // ****************************************************************
    assign lim_act = {lim_power, lim_avg, lim_neg_peak, lim_pos_peak};

    ecio_status ecio_status_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .mains_on (st_ff.mains_on),
        .outp_en  (st_ff.outp_en),
        .lim_act  (lim_act),
        .sw_busy  (st_ff.sw_busy),
        .seq_sync (st_ff.seq_sync),
        .stat     (stat)
    );

    // no enable of any kind sits between the flops and the pins
    assign mains_on_o = stat[0];
    assign outp_en_o  = stat[1];
    assign limiter_o  = stat[2];
    assign sw_busy_o  = stat[3];
    assign seq_sync_o = stat[5:4];

    // ****************************************************************
    // apb decode
    // ****************************************************************
    assign addr    = 12'(paddr);
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pwrite & ce;
    assign mapped  = (addr == ECIO_OFS_CTRL) || (addr == ECIO_OFS_LIMIT)
                  || (addr == ECIO_OFS_CMD)  || (addr == ECIO_OFS_PINS);
    // zero wait states; a frozen block holds the master off instead
    assign pready  = ce;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = st_ff.prdata;

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (addr)
            ECIO_OFS_CTRL: begin
                rd_val[ECIO_CTRL_MAINS] = st_ff.mains_on;
                rd_val[ECIO_CTRL_OUTP]  = st_ff.outp_en;
                rd_val[ECIO_CTRL_BUSY]  = st_ff.sw_busy;
                rd_val[ECIO_CTRL_SYNC +: ECIO_SYNC_W] = st_ff.seq_sync;
            end
            ECIO_OFS_LIMIT: begin
                rd_val[ECIO_N_LIM-1:0] = lim_act;
            end
            ECIO_OFS_CMD: begin
                rd_val[ECIO_N_CMD-1:0] = st_ff.cmd_flags;
            end
            ECIO_OFS_PINS: begin
                rd_val[ECIO_PINS_STAT +: ECIO_N_STAT]  = stat;
                rd_val[ECIO_PINS_CMDLVL +: ECIO_N_CMD] = cmd_level;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cmd_pulse = cmd_evt;
        // read data is captured in the setup phase, stable through access
        if (setup) begin
            nxt_st.prdata = rd_val;
        end
        if (wr_acc && addr == ECIO_OFS_CTRL) begin
            nxt_st.mains_on = pwdata[ECIO_CTRL_MAINS];
            nxt_st.outp_en  = pwdata[ECIO_CTRL_OUTP];
            nxt_st.sw_busy  = pwdata[ECIO_CTRL_BUSY];
            nxt_st.seq_sync = pwdata[ECIO_CTRL_SYNC +: ECIO_SYNC_W];
        end
        // pin commands beat a same-cycle software write; off beats on for safety
        if (cmd_evt[ECIO_CMD_ON]) begin
            nxt_st.outp_en = 1'b1;
        end
        if (cmd_evt[ECIO_CMD_OFF]) begin
            nxt_st.outp_en = 1'b0;
        end
        // write one to clear, a new event in the same cycle stays set
        if (wr_acc && addr == ECIO_OFS_CMD) begin
            nxt_st.cmd_flags = st_ff.cmd_flags & ~pwdata[ECIO_N_CMD-1:0];
        end
        nxt_st.cmd_flags = nxt_st.cmd_flags | cmd_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{mains_on: 1'b0, outp_en: 1'b0, sw_busy: 1'b0,
                       seq_sync: '0, cmd_flags: ECIO_RST_CMD,
                       cmd_pulse: '0, prdata: ECIO_RST_CTRL};
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign cmd_pulse = st_ff.cmd_pulse;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_mains_pin;
        ce |=> (mains_on_o == $past(st_ff.mains_on));
    endproperty
    a_mains_pin: assert property (p_mains_pin)
        else $error("mains status pin does not follow power state");

    property p_outp_pin;
        ce |=> (outp_en_o == $past(st_ff.outp_en));
    endproperty
    a_outp_pin: assert property (p_outp_pin)
        else $error("output status pin does not follow output state");

    sequence s_off_cmd;
        ce && cmd_evt[ECIO_CMD_OFF];
    endsequence

    sequence s_off_seen;
        !st_ff.outp_en ##1 (!$past(ce) || !outp_en_o);
    endsequence

    property p_off_cmd;
        s_off_cmd |=> s_off_seen;
    endproperty
    a_off_cmd: assert property (p_off_cmd)
        else $error("output off command did not reach the status pin");

    property p_limiter;
        ce |=> (limiter_o == $past(|lim_act));
    endproperty
    a_limiter: assert property (p_limiter)
        else $error("limiter pin does not match the limiter sources");

    property p_sync;
        ce |=> (seq_sync_o == $past(st_ff.seq_sync));
    endproperty
    a_sync: assert property (p_sync)
        else $error("sequence sync pins do not follow the sequence bits");

    property p_cmd_flag;
        (ce && cmd_evt != '0) |=> ((st_ff.cmd_flags & $past(cmd_evt)) == $past(cmd_evt));
    endproperty
    a_cmd_flag: assert property (p_cmd_flag)
        else $error("command edge was lost");

    property p_frozen;
        !ce |=> $stable(stat);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("status pins moved while the block was frozen");

    property p_busy;
        ce |=> (sw_busy_o == $past(st_ff.sw_busy));
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy pin does not follow software busy state");

    // software side of the status sources; pin commands only touch outp_en
    sequence s_ctrl_wr;
        wr_acc && addr == ECIO_OFS_CTRL;
    endsequence

    property p_ctrl_mains;
        s_ctrl_wr |=> (st_ff.mains_on == $past(pwdata[ECIO_CTRL_MAINS]));
    endproperty
    a_ctrl_mains: assert property (p_ctrl_mains)
        else $error("power state ignored a control write");

    property p_ctrl_busy;
        s_ctrl_wr |=> (st_ff.sw_busy == $past(pwdata[ECIO_CTRL_BUSY]));
    endproperty
    a_ctrl_busy: assert property (p_ctrl_busy)
        else $error("busy state ignored a control write");

    property p_ctrl_sync;
        s_ctrl_wr |=> (st_ff.seq_sync == $past(pwdata[ECIO_CTRL_SYNC +: ECIO_SYNC_W]));
    endproperty
    a_ctrl_sync: assert property (p_ctrl_sync)
        else $error("sequence bits ignored a control write");

    property p_limiter_idle;
        (ce && lim_act == '0) |=> !limiter_o;
    endproperty
    a_limiter_idle: assert property (p_limiter_idle)
        else $error("limiter pin high with no limiter active");

    // on alone switches the output; with off in the same cycle off wins
    sequence s_on_cmd;
        ce && cmd_evt[ECIO_CMD_ON] && !cmd_evt[ECIO_CMD_OFF];
    endsequence

    sequence s_on_seen;
        st_ff.outp_en ##1 (!$past(ce) || outp_en_o);
    endsequence

    property p_on_cmd;
        s_on_cmd |=> s_on_seen;
    endproperty
    a_on_cmd: assert property (p_on_cmd)
        else $error("output on command did not reach the status pin");

    property p_pulse;
        ce |=> (cmd_pulse == $past(cmd_evt));
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("command pulse does not follow the detected edge");

    // a pin held low must not raise a second event
    property p_fall_once;
        (ce && cmd_fall != '0) |=> ((cmd_fall & $past(cmd_fall)) == '0);
    endproperty
    a_fall_once: assert property (p_fall_once)
        else $error("one falling edge gave two events");

    property p_fall_level;
        (cmd_fall & cmd_level) == '0;
    endproperty
    a_fall_level: assert property (p_fall_level)
        else $error("edge reported while the synced pin is high");

    // flags only leave through a write of one to the command register
    property p_flag_sticky;
        (ce && !(wr_acc && addr == ECIO_OFS_CMD))
            |=> ((st_ff.cmd_flags & $past(st_ff.cmd_flags)) == $past(st_ff.cmd_flags));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("command flag cleared without a write");
endmodule

// file: ecio_ctl_model.sv
// partner model: external controller on the command and limiter lines
// assumes the bench calls its tasks from a process synchronous to pclk
`timescale 1ns/10ps
module ecio_ctl_model
    import ecio_pkg::*;
(
    input  wire logic                  pclk,
    output logic      [ECIO_N_CMD-1:0] cmd_pin_n,
    output logic      [ECIO_N_LIM-1:0] lim
);
    // ****************************************************************
    // command and limiter lines
    // ****************************************************************
    initial begin
        cmd_pin_n = ECIO_IDLE_PIN;
        lim       = '0;
    end

    // pull the chosen lines low, then back to idle high
    task automatic press(input logic [ECIO_N_CMD-1:0] m, input int len);
        @(posedge pclk);
        cmd_pin_n <= ~m;
        repeat (len) @(posedge pclk);
        cmd_pin_n <= ECIO_IDLE_PIN;
        // stay high long enough for the edge detector to re-arm
        repeat (4) @(posedge pclk);
    endtask

    task automatic set_lim(input logic [ECIO_N_LIM-1:0] v);
        @(posedge pclk);
        lim <= v;
    endtask
endmodule

// file: external_control_io_port_test.sv
// self-checking bench of the external control port
// assumes the design package and the controller model are compiled first
`timescale 1ns/10ps
module external_control_io_port_test
    import ecio_pkg::*;
;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic        pclk = 1'b0;
    logic        presetn, ce, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, v;
    logic        pready, pslverr, mains_on_o, outp_en_o, limiter_o, sw_busy_o;
    logic [1:0]  seq_sync_o;
    logic [6:0]  cmd_pin_n, cmd_pulse;
    logic [3:0]  lim;
    logic [32:0] q_rd[$];
    logic [6:0]  q_pu[$];
    int          n_mismatch = 0;
    int          checked    = 0;

    always #12.5 pclk = ~pclk;

    ecio_port #(.ADDR_W(12)) ecio_port_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_pin_n(cmd_pin_n),
        .lim_pos_peak(lim[0]), .lim_neg_peak(lim[1]), .lim_avg(lim[2]),
        .lim_power(lim[3]), .mains_on_o(mains_on_o), .outp_en_o(outp_en_o),
        .limiter_o(limiter_o), .sw_busy_o(sw_busy_o), .seq_sync_o(seq_sync_o),
        .cmd_pulse(cmd_pulse));

    ecio_ctl_model ctl (.pclk(pclk), .cmd_pin_n(cmd_pin_n), .lim(lim));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic tally(input logic [32:0] exp, input logic [32:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic cmp_read(input logic [32:0] exp);
        tally(exp, {pslverr, prdata});
    endtask

    task automatic cmp_pulse(input logic [6:0] exp);
        tally({26'h0, exp}, {26'h0, cmd_pulse});
    endtask

    task automatic cmp_stat(input logic [6:0] exp);
        tally({26'h0, exp}, {27'h0, seq_sync_o, sw_busy_o, limiter_o, outp_en_o, mains_on_o});
    endtask

    // one apb transfer; an idle cycle always precedes the setup phase
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        if (!w) q_rd.push_back(exp);
        // no wait count of its own: a stuck slave is the watchdog's business
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic finish_test();
        if (q_pu.size() != 0 || q_rd.size() != 0) n_mismatch++;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // result watcher: takes the oldest note whenever a result shows
    // ****************************************************************
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && q_rd.size() != 0)
            cmp_read(q_rd.pop_front());
        if (cmd_pulse !== 7'h00)
            cmp_pulse(q_pu.size() != 0 ? q_pu.pop_front() : 7'h00);
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        finish_test();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        ce      = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        seed    = 32'h0000_C3E9;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ECIO_OFS_CTRL, 32'h0, 33'h0);
        apb(1'b0, ECIO_OFS_PINS, 32'h0, 33'h0_0000_7F00);
        apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
        cmp_stat(7'h00);
        // every limiter combination, read back live too
        for (int i = 0; i < 16; i++) begin
            ctl.set_lim(i[3:0]);
            repeat (2) @(posedge pclk);
            #1 cmp_stat({4'h0, |i[3:0], 2'b00});
            apb(1'b0, ECIO_OFS_LIMIT, 32'h0, {29'h0, i[3:0]});
        end
        ctl.set_lim(4'h0);
        // random full words; only the five control bits stick
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            v = {27'h0, seed[4:0]};
            apb(1'b1, ECIO_OFS_CTRL, seed, 33'h0);
            repeat (2) @(posedge pclk);
            #1 cmp_stat({1'b0, v[4:2], 1'b0, v[1:0]});
            apb(1'b0, ECIO_OFS_CTRL, 32'h0, {1'b0, v});
        end
        apb(1'b1, ECIO_OFS_CTRL, 32'h0, 33'h0);
        // each command held low long: exactly one event apiece
        for (int c = 0; c < ECIO_N_CMD; c++) begin
            q_pu.push_back(7'h01 << c);
            ctl.press(7'h01 << c, 12);
        end
        #1 cmp_stat(7'h02);
        // off and on together: off wins
        q_pu.push_back(7'h03);
        ctl.press(7'h03, 3);
        #1 cmp_stat(7'h00);
        apb(1'b0, ECIO_OFS_CMD, 32'h0, 33'h0_0000_007F);
        apb(1'b1, ECIO_OFS_CMD, 32'h0000_0055, 33'h0);
        apb(1'b0, ECIO_OFS_CMD, 32'h0, 33'h0_0000_002A);
        // frozen: a control write lands in the register but not on the pins
        apb(1'b1, ECIO_OFS_CTRL, 32'h0000_001F, 33'h0);
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        #1 cmp_stat(7'h00);
        @(posedge pclk);
        ce <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 cmp_stat(7'h3B);
        repeat (4) @(posedge pclk);
        finish_test();
    end
endmodule
